// File: inc/pddr_pkg.sv
package pddr_pkg;
  localparam int PORT_WIDTH = 8;
  // register selects on the cpu byte port
  localparam logic [0:0] SEL_OUTPUT_LATCH = 1'h0;
  localparam logic [0:0] SEL_DIRECTION = 1'h1;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] DIRECTION_RESET = 8'h00;
  localparam logic [7:0] DIRECTION_READ_VALUE = 8'hff;
  localparam logic [7:0] READ_DATA_RESET = 8'h00;

  typedef struct packed {
    logic valid;
    logic write;
    logic [0:0] select;
    logic [7:0] data;
  } pddr_access_t;

  typedef struct packed {
    logic [7:0] pinOut;
    logic [7:0] pinOutEnable;
  } pddr_pins_t;

  typedef struct packed {
    logic [7:0] portOutputLatch;
    logic [7:0] portDirectionControl;
    logic [7:0] readData;
    logic readValid;
    pddr_pins_t pins;
  } pddr_state_t;
endpackage : pddr_pkg

// File: hdl/pddr_port.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - data read returns pin level for each bit configured as input
// - data read returns latch value for each bit configured as output
// - direction register is write-only; reading it returns all ones
// - direction bit zero makes pin input, one makes it output
// - output pin drives its latch bit level
// - data write stores all eight bits, input pins included
// - reset clears all direction bits so every pin starts as input
module pddr_port
#(
  parameter int WIDTH = pddr_pkg::PORT_WIDTH
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire pddr_pkg::pddr_access_t access,
  input wire logic [7:0] pinIn,
  output logic [7:0] readData,
  output logic readValid,
  output pddr_pkg::pddr_pins_t pins
);
  import pddr_pkg::*;

  // one cpu byte access, split by target and kind
  typedef struct packed {
    logic writeLatch;
    logic writeDirection;
    logic readLatch;
    logic readDirection;
  } pddr_decode_t;

  pddr_state_t state;
  pddr_state_t next_state;
  pddr_decode_t decoded;
  logic [WIDTH-1:0] portRead;
  logic [WIDTH-1:0] nextLatch;
  logic [WIDTH-1:0] nextDirection;

  // carriers are one byte wide, no other width is served
  if (WIDTH != PORT_WIDTH)
  begin : gen_check_width
    $error("pddr_port: WIDTH must equal the carrier width");
  end

  // the two targets must decode apart
  if (SEL_OUTPUT_LATCH == SEL_DIRECTION)
  begin : gen_check_select
    $error("pddr_port: latch and direction selects collide");
  end

  // every pin must come out of reset as an input
  if (DIRECTION_RESET != '0)
  begin : gen_check_dir_reset
    $error("pddr_port: direction reset must leave all pins input");
  end

  // the direction read must come back as all ones
  if (DIRECTION_READ_VALUE != '1)
  begin : gen_check_dir_read
    $error("pddr_port: direction read value must be all ones");
  end

  function automatic logic accessHits(
    input pddr_access_t req,
    input logic isWrite,
    input logic [0:0] sel
  );
    accessHits = req.valid && (req.write == isWrite)
      && (req.select == sel);
  endfunction : accessHits

  function automatic pddr_decode_t decodeAccess(
    input pddr_access_t req
  );
    pddr_decode_t result;
    result.writeLatch = accessHits(req, 1'b1, SEL_OUTPUT_LATCH);
    result.writeDirection = accessHits(req, 1'b1, SEL_DIRECTION);
    result.readLatch = accessHits(req, 1'b0, SEL_OUTPUT_LATCH);
    result.readDirection = accessHits(req, 1'b0, SEL_DIRECTION);
    decodeAccess = result;
  endfunction : decodeAccess

  // read answer for the decoded access; keeps the old one when idle
  function automatic logic [7:0] readback(
    input pddr_decode_t dec,
    input logic [7:0] portValue,
    input logic [7:0] heldValue
  );
    logic [1:0] kind;
    kind = {dec.readDirection, dec.readLatch};
    unique case (kind)
      2'h1:
      begin
        readback = portValue;
      end
      2'h2:
      begin
        // direction contents never reach the read path
        readback = DIRECTION_READ_VALUE;
      end
      default:
      begin
        readback = heldValue;
      end
    endcase
  endfunction : readback

  assign decoded = decodeAccess(access);

  for (genvar pinIdx = 0; pinIdx < WIDTH; pinIdx++)
  begin : gen_pin
    logic driven;
    logic latchBit;
    logic padBit;
    logic dataBit;

    assign driven = state.portDirectionControl[pinIdx];
    assign latchBit = state.portOutputLatch[pinIdx];
    assign padBit = pinIn[pinIdx];
    assign dataBit = access.data[pinIdx];

    // input pins show the pad, output pins their latch bit
    assign portRead[pinIdx] = driven ?
      latchBit : padBit;

    // a byte write lands in every latch bit, driven or not
    assign nextLatch[pinIdx] = decoded.writeLatch ?
      dataBit : latchBit;

    // a one in the direction bit turns the pad driver on
    assign nextDirection[pinIdx] = decoded.writeDirection ?
      dataBit : driven;
  end

  always_comb
  begin
    next_state = state;

    next_state.portOutputLatch = nextLatch;
    next_state.portDirectionControl = nextDirection;

    next_state.readValid = decoded.readLatch || decoded.readDirection;
    next_state.readData = readback(decoded, portRead, state.readData);

    // pads follow the registers they mirror
    next_state.pins.pinOutEnable = nextDirection;
    next_state.pins.pinOut = nextLatch;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      state.portOutputLatch <= LATCH_RESET;
      state.portDirectionControl <= DIRECTION_RESET;
      state.readData <= READ_DATA_RESET;
      state.readValid <= 1'b0;
      state.pins.pinOut <= LATCH_RESET;
      state.pins.pinOutEnable <= DIRECTION_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign readData = state.readData;
  assign readValid = state.readValid;
  assign pins = state.pins;
endmodule : pddr_port

`default_nettype wire

// File: verif/pddr_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module pddr_pin_model
(
  input wire pddr_pkg::pddr_pins_t pins,
  input wire logic [7:0] ext,
  output logic [7:0] pinIn
);
  // driven pins show latch, others the outside level
  assign pinIn = (pins.pinOutEnable & pins.pinOut) |
    (~pins.pinOutEnable & ext);
endmodule : pddr_pin_model
`default_nettype wire

// File: verif/pddr_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module pddr_asserts
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire pddr_pkg::pddr_access_t access,
  input wire logic [7:0] pinIn,
  input wire logic [7:0] readData,
  input wire logic readValid,
  input wire pddr_pkg::pddr_pins_t pins
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence rd(s);
    access.valid && !access.write && access.select == s;
  endsequence
  sequence wr(s);
    access.valid && access.write && access.select == s;
  endsequence
  AST_RDIN: assert property (rd(0) |=> ((readData ^ $past(pinIn)) &
    ~pins.pinOutEnable) == 8'h00) else $error("input bit read");
  AST_RDOUT: assert property (rd(0) |=> ((readData ^ pins.pinOut) &
    pins.pinOutEnable) == 8'h00) else $error("output bit read");
  AST_DIRRD: assert property (rd(1) |=> readValid && readData == 8'hff)
    else $error("direction read");
  AST_DIRWR: assert property (wr(1) |=> pins.pinOutEnable ==
    $past(access.data)) else $error("direction write");
  AST_LATWR: assert property (wr(0) |=> pins.pinOut == $past(access.data))
    else $error("latch write");
  AST_RVAL: assert property (!(access.valid && !access.write) |=> !readValid)
    else $error("stray read valid");
  AST_RST: assert property ($fell(reset) |-> pins.pinOutEnable == 8'h00)
    else $error("reset direction");
endmodule : pddr_asserts
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pddr_pkg::*;
  logic sys_clk = 0, reset = 1, readValid;
  pddr_access_t access = '0;
  logic [7:0] pinIn, readData, ext = 8'h40;
  pddr_pins_t pins;
  int n_fail = 0, check_count = 0, cyc = 0;
  always #25 sys_clk = ~sys_clk;
  pddr_port dut (.sys_clk(sys_clk), .reset(reset), .access(access),
    .pinIn(pinIn), .readData(readData), .readValid(readValid), .pins(pins));
  pddr_pin_model pm (.pins(pins), .ext(ext), .pinIn(pinIn));
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task acc(input logic w, input logic s, input logic [7:0] d);
    @(posedge sys_clk) #1 access = '{1'b1, w, s, d};
    @(posedge sys_clk) #1 access.valid = 0;
  endtask : acc
  task t_bit_set_instruction;
    acc(1, 1, 8'h3f); acc(1, 0, 8'h80); acc(0, 0, 8'h00);
    chk("read", readData, 8'h40);
    acc(1, 0, readData | 8'h01);
    chk("pins", pinIn, 8'h41);
    acc(1, 1, 8'hff);
    chk("latch", pins.pinOut, 8'h41);
  endtask : t_bit_set_instruction
  task t_bit_clear_instruction;
    acc(1, 1, 8'h3f); acc(0, 1, 8'h00);
    chk("dir", readData, 8'hff);
    acc(1, 1, readData & 8'hfe);
    chk("oe", pins.pinOutEnable, 8'hfe);
  endtask : t_bit_clear_instruction
  task rd(input logic s, input string n, input logic [7:0] e);
    @(posedge sys_clk) #1 access = '{1'b1, 1'b0, s, 8'h00};
    @(posedge sys_clk) #1 access.valid = 0;
    chk("valid", {7'h00, readValid}, 8'h01);
    chk(n, readData, e);
  endtask : rd
  task t_shadow;
    logic [7:0] latchCopy;
    logic [7:0] dirCopy;
    latchCopy = 8'h80;
    dirCopy = 8'h3f;
    acc(1, 0, latchCopy);
    acc(1, 1, dirCopy);
    latchCopy = latchCopy | 8'h01;
    acc(1, 0, latchCopy);
    chk("shadow latch", pins.pinOut, 8'h81);
    dirCopy = dirCopy & 8'hfe;
    acc(1, 1, dirCopy);
    chk("shadow dir", pins.pinOutEnable, 8'h3e);
    ext = 8'h81;
    rd(0, "shadow read", 8'h81);
    rd(1, "shadow dir read", 8'hff);
  endtask : t_shadow
  task print_verdict;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    repeat (6) @(posedge sys_clk);
    #1 reset = 0;
    chk("reset", pins.pinOutEnable, 8'h00);
    t_bit_set_instruction;
    t_bit_clear_instruction;
    t_shadow;
    print_verdict;
  end
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc > 300)
    begin
      n_fail++;
      print_verdict;
    end
  end
endmodule : tb_top
bind pddr_port pddr_asserts chk_i (.sys_clk(sys_clk), .reset(reset),
  .access(access), .pinIn(pinIn), .readData(readData),
  .readValid(readValid), .pins(pins));
`default_nettype wire
